// File: src/fmc_modem.sv
// ffsk/msk modem control: rate selection, tx path, rx demodulation and axi4-lite registers
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - carrier detect high while valid tones received
// - rx clock is flywheel locked to data
// - low-rate set: 1200 baud, 1200/1800 Hz tones
// - both selects low: 2400 baud, 1200/2400 Hz
// - high-rate only with 4.032 MHz reference: 4800 baud, 2400/4800 Hz
// - reference select picks 4.032 or 1.008 MHz
// - selects reset to pull-up/pull-down defaults
// - transmitter runs while its low enable asserted
// - tx bit clock: one period per bit
// - rx enable high gives raw demodulated data
// - retimed data clocked by recovered clock
// - carrier detect from signal-versus-noise integration
// - rx powersave: retimed zero, others static
// - tx and rx enable independently
// - baud follows select and reference pins
// - tx off: bit clock high, tone undriven
module fmc_modem (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite write channels
	input wire logic [fmc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [fmc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// transmit pins
	input wire logic transmitOnLow,
	input wire logic txData,
	output logic txSync,
	output logic txTone,
	output logic txToneOe,
	// receive pins
	input wire logic rxEnable,
	input wire logic rxSignal,
	output logic rawData,
	output logic retimedData,
	output logic rxClock,
	output logic carrierDetect
);
	localparam int W = fmc_pkg::TICK_W;

	fmc_pkg::fmc_cfg_t cfg_r;
	logic [7:0] cdThresh_r;
	logic [fmc_pkg::NCO_W-1:0] ncoAcc_r;
	logic refTick_r;
	fmc_pkg::fmc_rate_t rate;
	logic unsupported;
	logic [W-1:0] bitLen;
	logic [W-1:0] markLen;
	logic [W-1:0] spaceLen;
	logic txActive;

	// reference tick: shared divider chain for both sections
	logic [fmc_pkg::NCO_W-1:0] ncoInc;
	logic [fmc_pkg::NCO_W-1:0] ncoSum;
	assign ncoInc = cfg_r.refSel ? fmc_pkg::NCO_W'(fmc_pkg::REF_HIGH_HZ) : fmc_pkg::NCO_W'(fmc_pkg::REF_LOW_HZ);
	assign ncoSum = ncoAcc_r + ncoInc;

	always_ff @(posedge clk) begin
		if (rst) begin
			ncoAcc_r <= '0;
			refTick_r <= 1'b0;
		end else if (ncoSum >= fmc_pkg::NCO_W'(fmc_pkg::CLK_HZ)) begin
			ncoAcc_r <= ncoSum - fmc_pkg::NCO_W'(fmc_pkg::CLK_HZ);
			refTick_r <= 1'b1;
		end else begin
			ncoAcc_r <= ncoSum;
			refTick_r <= 1'b0;
		end
	end

	// baud selection from the three selects
	always_comb begin
		unsupported = 1'b0;
		if (cfg_r.lowRate) begin
			rate = fmc_pkg::RATE_SLOW;
		end else if (cfg_r.highRate && cfg_r.refSel) begin
			rate = fmc_pkg::RATE_FAST;
		end else begin
			rate = fmc_pkg::RATE_MID;
			unsupported = cfg_r.highRate;
		end
	end

	assign bitLen = fmc_pkg::bit_ticks(rate, cfg_r.refSel);
	assign markLen = fmc_pkg::mark_half(rate, bitLen);
	assign spaceLen = fmc_pkg::space_half(rate, bitLen);
	assign txActive = !transmitOnLow;

	fmc_tone_gen u_tone (
		.clk(clk),
		.rst(rst),
		.refTick(refTick_r),
		.bitLen(bitLen),
		.markLen(markLen),
		.spaceLen(spaceLen),
		.txActive(txActive),
		.txData(txData),
		.txSync(txSync),
		.txTone(txTone),
		.txToneOe(txToneOe)
	);

	// receive: half-cycle timing demodulator
	logic rxPrev_r;
	logic [W-1:0] interval_r;
	logic raw_r;
	logic rxEdge;
	logic intervalValid;
	logic [W:0] decideLevel;
	assign rxEdge = rxSignal != rxPrev_r;
	assign decideLevel = ({1'b0, markLen} + {1'b0, spaceLen}) >> 1;
	assign intervalValid = (interval_r >= spaceLen - (spaceLen >> 2)) && (interval_r <= markLen + (markLen >> 2));

	always_ff @(posedge clk) begin
		if (rst) begin
			rxPrev_r <= 1'b0;
			interval_r <= '0;
			raw_r <= 1'b0;
		end else if (rxEnable) begin
			rxPrev_r <= rxSignal;
			if (rxEdge) begin
				interval_r <= '0;
				raw_r <= {1'b0, interval_r} > decideLevel;
			end else if (refTick_r && interval_r < (markLen << 1)) begin
				interval_r <= interval_r + 1'b1;
			end else if (refTick_r) begin
				interval_r <= '0;
			end
		end
	end

	// carrier detect: integrate good half-cycles against noise and silence
	logic [7:0] cdInt_r;
	logic cd_r;
	logic silent;
	assign silent = refTick_r && !rxEdge && interval_r >= (markLen << 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			cdInt_r <= '0;
		end else if (rxEnable) begin
			if (rxEdge && intervalValid) begin
				cdInt_r <= (cdInt_r > 8'hff - fmc_pkg::CD_STEP_UP) ? 8'hff : cdInt_r + fmc_pkg::CD_STEP_UP;
			end else if ((rxEdge && !intervalValid) || silent) begin
				cdInt_r <= (cdInt_r < fmc_pkg::CD_STEP_DOWN) ? 8'h00 : cdInt_r - fmc_pkg::CD_STEP_DOWN;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cd_r <= 1'b0;
		end else if (rxEnable) begin
			cd_r <= cdInt_r >= cdThresh_r;
		end
	end

	// flywheel clock recovery: nudge phase toward data transitions
	logic [W-1:0] phase_r;
	logic rawPrev_r;
	logic rxClk_r;
	logic retimed_r;
	logic [W-1:0] step;
	logic [W-1:0] halfBit;
	logic [W-1:0] phaseInc;
	assign step = bitLen >> fmc_pkg::DPLL_SHIFT;
	assign halfBit = bitLen >> 1;
	assign phaseInc = (phase_r >= bitLen - 1'b1) ? '0 : phase_r + 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_r <= '0;
			rawPrev_r <= 1'b0;
		end else if (rxEnable) begin
			rawPrev_r <= raw_r;
			if (raw_r != rawPrev_r && phase_r < halfBit) begin
				phase_r <= (phase_r > step) ? phase_r - step : '0;
			end else if (raw_r != rawPrev_r) begin
				phase_r <= (phase_r + step >= bitLen) ? '0 : phase_r + step;
			end else if (refTick_r) begin
				phase_r <= phaseInc;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rxClk_r <= 1'b0;
		end else if (rxEnable) begin
			rxClk_r <= phase_r >= halfBit;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !rxEnable) begin
			retimed_r <= 1'b0;
		end else if (refTick_r && phase_r == halfBit) begin
			retimed_r <= raw_r;
		end
	end

	assign rawData = raw_r;
	assign retimedData = retimed_r;
	assign rxClock = rxClk_r;
	assign carrierDetect = cd_r;

	// axi4-lite slave
	logic awGot_r;
	logic wGot_r;
	logic [fmc_pkg::ADDR_W-1:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	fmc_pkg::fmc_status_t status;

	assign s_axi_awready = !awGot_r && !bvalid_r;
	assign s_axi_wready = !wGot_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	assign status = '{cdLevel: cdInt_r, unsupported: unsupported, rate: rate, txSync: txSync,
		retimed: retimed_r, raw: raw_r, rxClock: rxClk_r, carrierDetect: cd_r};

	always_ff @(posedge clk) begin
		if (rst) begin
			awGot_r <= 1'b0;
			wGot_r <= 1'b0;
			awAddr_r <= '0;
			wData_r <= '0;
			wStrb_r <= '0;
		end else if (awGot_r && wGot_r) begin
			awGot_r <= 1'b0;
			wGot_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awGot_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wGot_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_r <= fmc_pkg::CFG_RST;
			cdThresh_r <= fmc_pkg::CD_THRESH_RST;
			bvalid_r <= 1'b0;
			bresp_r <= fmc_pkg::RESP_OKAY;
		end else if (awGot_r && wGot_r) begin
			bvalid_r <= 1'b1;
			bresp_r <= fmc_pkg::RESP_OKAY;
			if (awAddr_r == fmc_pkg::ADDR_CTRL && wStrb_r[0]) begin
				cfg_r <= wData_r[2:0];
			end else if (awAddr_r == fmc_pkg::ADDR_CDCFG && wStrb_r[0]) begin
				cdThresh_r <= wData_r[7:0];
			end else if (awAddr_r != fmc_pkg::ADDR_CTRL && awAddr_r != fmc_pkg::ADDR_CDCFG) begin
				bresp_r <= fmc_pkg::RESP_SLVERR;
			end
		end else if (bvalid_r && s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= fmc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= fmc_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				fmc_pkg::ADDR_CTRL: rdata_r <= {29'h0, cfg_r};
				fmc_pkg::ADDR_STATUS: rdata_r <= {16'h0, status};
				fmc_pkg::ADDR_CDCFG: rdata_r <= {24'h0, cdThresh_r};
				default: begin
					rdata_r <= '0;
					rresp_r <= fmc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_slowRate;
		cfg_r.lowRate |-> rate == fmc_pkg::RATE_SLOW && markLen == (bitLen >> 1) && spaceLen == bitLen / 3;
	endproperty
	a_slowRate: assert property (p_slowRate) else $error("low-rate select not at 1200 baud");

	property p_midRate;
		!cfg_r.lowRate && !cfg_r.highRate |-> rate == fmc_pkg::RATE_MID && markLen == bitLen;
	endproperty
	a_midRate: assert property (p_midRate) else $error("both selects low not at 2400 baud");

	property p_fastRate;
		!cfg_r.lowRate && cfg_r.highRate |-> (rate == fmc_pkg::RATE_FAST) == cfg_r.refSel;
	endproperty
	a_fastRate: assert property (p_fastRate) else $error("4800 baud decode wrong");

	property p_bitLen;
		cfg_r.refSel && rate == fmc_pkg::RATE_FAST |-> bitLen == 12'h348;
	endproperty
	a_bitLen: assert property (p_bitLen) else $error("4800 baud bit length wrong");

	property p_refSpacing;
		refTick_r |=> !refTick_r ##1 !refTick_r;
	endproperty
	a_refSpacing: assert property (p_refSpacing) else $error("reference ticks too close");

	property p_retimedPowersave;
		!rxEnable |=> !retimedData;
	endproperty
	a_retimedPowersave: assert property (p_retimedPowersave) else $error("retimed data not zero in powersave");

	property p_rxStatic;
		!rxEnable ##1 !rxEnable |-> $stable(rxClock) && $stable(carrierDetect);
	endproperty
	a_rxStatic: assert property (p_rxStatic) else $error("rx outputs moved in powersave");

	property p_cdRise;
		$rose(carrierDetect) |-> $past(rxEnable) && $past(cdInt_r) >= $past(cdThresh_r);
	endproperty
	a_cdRise: assert property (p_cdRise) else $error("carrier detect rose without signal");

	property p_clockRise;
		$rose(rxClock) |-> $past(phase_r) >= $past(halfBit);
	endproperty
	a_clockRise: assert property (p_clockRise) else $error("rx clock edge off recovered phase");

	property p_writeAnswer;
		awGot_r && wGot_r |=> s_axi_bvalid;
	endproperty
	a_writeAnswer: assert property (p_writeAnswer) else $error("write response missing");

	c_carrier: cover property ($rose(carrierDetect));
	c_fastTx: cover property (rate == fmc_pkg::RATE_FAST && txToneOe);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_retimedOne: cover property ($rose(retimedData));
endmodule
`default_nettype wire

// File: src/fmc_pkg.sv
// shared constants, types and timing helpers for the ffsk/msk modem control block
package fmc_pkg;

	// clock rates in hertz
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned REF_LOW_HZ = 1008000;
	localparam int unsigned REF_HIGH_HZ = 4032000;

	// baud rates
	localparam int unsigned BAUD_SLOW = 1200;
	localparam int unsigned BAUD_MID = 2400;
	localparam int unsigned BAUD_FAST = 4800;

	// widths
	localparam int TICK_W = 12;
	localparam int NCO_W = 25;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_CDCFG = 8'h08;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// carrier detect integrator and clock recovery tuning, reset values
	localparam logic [7:0] CD_THRESH_RST = 8'h80;
	localparam logic [7:0] CD_STEP_UP = 8'h04;
	localparam logic [7:0] CD_STEP_DOWN = 8'h08;
	localparam int DPLL_SHIFT = 4;

	typedef enum logic [1:0] {RATE_SLOW, RATE_MID, RATE_FAST} fmc_rate_t;

	// control register, bits 2:0
	typedef struct packed {
		logic refSel;
		logic highRate;
		logic lowRate;
	} fmc_cfg_t;

	// pull-up on low-rate select, pull-downs on the others
	localparam fmc_cfg_t CFG_RST = '{refSel: 1'b0, highRate: 1'b0, lowRate: 1'b1};

	// status register, bits 15:0
	typedef struct packed {
		logic [7:0] cdLevel;
		logic unsupported;
		logic [1:0] rate;
		logic txSync;
		logic retimed;
		logic raw;
		logic rxClock;
		logic carrierDetect;
	} fmc_status_t;

	// reference ticks per bit
	function automatic logic [TICK_W-1:0] bit_ticks(input fmc_rate_t rate, input logic refSel);
		int unsigned hz;
		int unsigned baud;
		hz = refSel ? REF_HIGH_HZ : REF_LOW_HZ;
		baud = (rate == RATE_SLOW) ? BAUD_SLOW : ((rate == RATE_MID) ? BAUD_MID : BAUD_FAST);
		return TICK_W'(hz / baud);
	endfunction

	// half-cycle of the one tone
	function automatic logic [TICK_W-1:0] mark_half(input fmc_rate_t rate, input logic [TICK_W-1:0] bitLen);
		return (rate == RATE_SLOW) ? (bitLen >> 1) : bitLen;
	endfunction

	// half-cycle of the zero tone
	function automatic logic [TICK_W-1:0] space_half(input fmc_rate_t rate, input logic [TICK_W-1:0] bitLen);
		return (rate == RATE_SLOW) ? TICK_W'(bitLen / 3) : (bitLen >> 1);
	endfunction

endpackage

// File: src/fmc_tone_gen.sv
// transmit bit timing, data intake and phase-continuous tone generation
`timescale 1ns/1ns
`default_nettype none
module fmc_tone_gen (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timing from the shared dividers
	input wire logic refTick,
	input wire logic [fmc_pkg::TICK_W-1:0] bitLen,
	input wire logic [fmc_pkg::TICK_W-1:0] markLen,
	input wire logic [fmc_pkg::TICK_W-1:0] spaceLen,
	// host side
	input wire logic txActive,
	input wire logic txData,
	// line side
	output logic txSync,
	output logic txTone,
	output logic txToneOe
);
	logic [fmc_pkg::TICK_W-1:0] bitCnt_r;
	logic [fmc_pkg::TICK_W-1:0] halfCnt_r;
	logic curBit_r;
	logic tone_r;
	logic sync_r;
	logic oe_r;
	logic [fmc_pkg::TICK_W-1:0] halfLen;
	logic bitEnd;
	logic halfEnd;

	assign halfLen = curBit_r ? markLen : spaceLen;
	assign bitEnd = bitCnt_r >= bitLen - 1'b1;
	assign halfEnd = halfCnt_r >= halfLen - 1'b1;

	always_ff @(posedge clk) begin
		if (rst || !txActive) begin
			bitCnt_r <= '0;
		end else if (refTick) begin
			bitCnt_r <= bitEnd ? '0 : bitCnt_r + 1'b1;
		end
	end

	// a bit edge always ends the current half-cycle, so tone changes land on crossings
	always_ff @(posedge clk) begin
		if (rst || !txActive) begin
			halfCnt_r <= '0;
			tone_r <= 1'b0;
		end else if (refTick) begin
			halfCnt_r <= (halfEnd || bitEnd) ? '0 : halfCnt_r + 1'b1;
			if (halfEnd || bitEnd) begin
				tone_r <= ~tone_r;
			end
		end
	end

	// one sample per bit, taken as the bit clock rises
	always_ff @(posedge clk) begin
		if (rst) begin
			curBit_r <= 1'b1;
		end else if (!txActive || (refTick && bitEnd)) begin
			curBit_r <= txData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !txActive) begin
			sync_r <= 1'b1;
			oe_r <= 1'b0;
		end else begin
			sync_r <= bitCnt_r < (bitLen >> 1);
			oe_r <= 1'b1;
		end
	end

	assign txSync = sync_r;
	assign txTone = tone_r;
	assign txToneOe = oe_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_toneAtCrossing;
		txActive && $past(txActive) && $changed(tone_r) |-> $past(refTick) && ($past(halfEnd) || $past(bitEnd));
	endproperty
	a_toneAtCrossing: assert property (p_toneAtCrossing) else $error("tone changed off a half-cycle edge");

	property p_bitHeld;
		txActive && $past(txActive) && !$past(refTick && bitEnd) |-> $stable(curBit_r);
	endproperty
	a_bitHeld: assert property (p_bitHeld) else $error("tx bit changed inside a bit");

	property p_syncIdle;
		!txActive |=> txSync && !txToneOe;
	endproperty
	a_syncIdle: assert property (p_syncIdle) else $error("idle transmitter not parked");

	c_toneToggle: cover property (txActive && $changed(tone_r));
endmodule
`default_nettype wire

// File: verif/fmc_host_model.sv
// host controller and line model: paces tx data, loops the tone back to rx
`timescale 1ns/1ns
`default_nettype none
module fmc_host_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// modem tx pins
	input wire logic txSync,
	input wire logic txTone,
	input wire logic txToneOe,
	// bench side
	input wire logic bitIn,
	// driven pins
	output logic txData = 1'b0,
	output logic rxSignal
);
	logic noiseR = 1'b0;
	// new bit only while the bit clock is low
	always @(posedge clk) begin
		if (rst || !txSync) begin
			txData <= bitIn;
		end
	end
	// released line wanders every cycle
	always @(posedge clk) begin
		noiseR <= ~noiseR;
	end
	assign rxSignal = txToneOe ? txTone : noiseR;
endmodule
`default_nettype wire

// File: verif/ffsk_msk_modem_control_tb.sv
// self-checking bench for the modem control block
`timescale 1ns/1ns
`default_nettype none
module ffsk_msk_modem_control_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awAddr = 8'h00;
	logic awValid = 1'b0;
	logic awReady;
	logic [31:0] wData = 32'h0;
	logic [3:0] wStrb = 4'hf;
	logic wValid = 1'b0;
	logic wReady;
	logic [1:0] bResp;
	logic bValid;
	logic bReady = 1'b0;
	logic [7:0] arAddr = 8'h00;
	logic arValid = 1'b0;
	logic arReady;
	logic [31:0] rData;
	logic [1:0] rResp;
	logic rValid;
	logic rReady = 1'b0;
	logic transmitOnLow = 1'b1;
	logic rxEnable = 1'b0;
	logic bitIn = 1'b1;
	logic txData, txSync, txTone, txToneOe, rxSignal, rawData, retimedData, rxClock, carrierDetect;
	logic syncQ = 1'b1, toneQ = 1'b0, rxQ = 1'b0;
	int cyc = 0, hiCyc = 0, tog = 0, rxr = 0, rises = 0, lastPeriod = 0, lastHigh = 0, lastTog = 0, lastRx = 0;
	int errTotal = 0;
	int checks = 0;
	logic [31:0] rd;
	logic [1:0] resp;

	fmc_modem u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
		.s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .transmitOnLow(transmitOnLow),
		.txData(txData), .txSync(txSync), .txTone(txTone), .txToneOe(txToneOe), .rxEnable(rxEnable),
		.rxSignal(rxSignal), .rawData(rawData), .retimedData(retimedData), .rxClock(rxClock),
		.carrierDetect(carrierDetect));
	fmc_host_model u_host (.clk(clk), .rst(rst), .txSync(txSync), .txTone(txTone), .txToneOe(txToneOe),
		.bitIn(bitIn), .txData(txData), .rxSignal(rxSignal));

	initial begin
		forever #20 clk = ~clk;
	end

	// per bit: length, high time, tone toggles, recovered clock rises
	always @(posedge clk) begin
		syncQ <= txSync;
		toneQ <= txTone;
		rxQ <= rxClock;
		if (txSync === 1'b1 && syncQ === 1'b0) begin
			lastPeriod <= cyc;
			lastHigh <= hiCyc;
			lastTog <= tog;
			lastRx <= rxr;
			cyc <= 1;
			hiCyc <= 1;
			tog <= int'(txTone !== toneQ);
			rxr <= int'(rxClock === 1'b1 && rxQ === 1'b0);
			rises <= rises + 1;
		end else begin
			cyc <= cyc + 1;
			hiCyc <= hiCyc + int'(txSync === 1'b1);
			tog <= tog + int'(txTone !== toneQ);
			rxr <= rxr + int'(rxClock === 1'b1 && rxQ === 1'b0);
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv, input string what);
		checks++;
		if (seen !== expv) begin
			errTotal++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, expv);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic awHs, wHs, done;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!done && n < 100) begin
			@(negedge clk);
			n++;
			awHs = awValid && awReady;
			wHs = wValid && wReady;
			done = (bValid === 1'b1);
			resp = bResp;
			@(posedge clk);
			if (awHs) awValid <= 1'b0;
			if (wHs) wValid <= 1'b0;
			if (done) bReady <= 1'b0;
		end
		chk(done, 1'b1, "write answer");
	endtask

	task automatic axi_rd(input logic [7:0] a);
		int n;
		logic arHs, done;
		n = 0;
		done = 1'b0;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		while (!done && n < 100) begin
			@(negedge clk);
			n++;
			arHs = arValid && arReady;
			done = (rValid === 1'b1);
			rd = rData;
			resp = rResp;
			@(posedge clk);
			if (arHs) arValid <= 1'b0;
			if (done) rReady <= 1'b0;
		end
		chk(done, 1'b1, "read answer");
	endtask

	task automatic wait_rises(input int k);
		int t, n;
		t = rises + k;
		n = 0;
		while (rises < t && n < 12000 * k) begin
			@(posedge clk);
			n++;
		end
		@(negedge clk);
		chk(rises >= t, 1'b1, "tx bit clock stalled");
	endtask

	task automatic t_reset_regs;
		@(negedge clk);
		chk(txSync, 1'b1, "idle bit clock");
		chk(txToneOe, 1'b0, "idle tone enable");
		chk(retimedData, 1'b0, "idle retimed data");
		axi_rd(fmc_pkg::ADDR_CTRL);
		chk(rd, 32'h1, "select defaults");
		axi_rd(fmc_pkg::ADDR_CDCFG);
		chk(rd, 32'h80, "threshold default");
		axi_rd(8'h0c);
		chk(resp, fmc_pkg::RESP_SLVERR, "unmapped read");
		chk(rd, 32'h0, "unmapped data");
		axi_wr(fmc_pkg::ADDR_STATUS, 32'h0, 4'hf);
		chk(resp, fmc_pkg::RESP_SLVERR, "status write");
		axi_wr(fmc_pkg::ADDR_CTRL, 32'hfffffff8, 4'he);
		axi_rd(fmc_pkg::ADDR_CTRL);
		chk(rd, 32'h1, "unstrobed write");
		axi_wr(fmc_pkg::ADDR_CTRL, 32'hfffffffa, 4'hf);
		axi_rd(fmc_pkg::ADDR_CTRL);
		chk(rd, 32'h2, "upper bits dropped");
		$display("test reset_regs done");
	endtask

	task automatic t_rate_table;
		logic [2:0] sel [7] = '{3'h1, 3'h0, 3'h5, 3'h4, 3'h6, 3'h2, 3'h7};
		logic [2:0] expv [7] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h2, 3'h5, 3'h0};
		for (int i = 0; i < 7; i++) begin
			axi_wr(fmc_pkg::ADDR_CTRL, {29'h0, sel[i]}, 4'hf);
			axi_rd(fmc_pkg::ADDR_STATUS);
			chk(rd[7:5], expv[i], "rate decode");
		end
		$display("test rate_table done");
	endtask

	task automatic t_tx_timing;
		int bitClk;
		bitClk = fmc_pkg::CLK_HZ / fmc_pkg::BAUD_FAST;
		axi_wr(fmc_pkg::ADDR_CTRL, 32'h6, 4'hf);
		@(posedge clk);
		transmitOnLow <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(txToneOe, 1'b1, "tone enable lag");
		wait_rises(3);
		chk(lastPeriod >= bitClk - 2 && lastPeriod <= bitClk + 2, 1'b1, "bit clock period");
		chk(lastHigh >= bitClk / 2 - 2 && lastHigh <= bitClk / 2 + 2, 1'b1, "bit clock high");
		$display("test tx_timing done");
	endtask

	task automatic t_loopback;
		axi_wr(fmc_pkg::ADDR_CDCFG, 32'h10, 4'hf);
		@(posedge clk);
		rxEnable <= 1'b1;
		bitIn <= 1'b1;
		wait_rises(3);
		chk(lastTog, 1, "mark half cycle");
		chk(rawData, 1'b1, "raw mark");
		chk(retimedData, 1'b1, "retimed mark");
		@(posedge clk);
		bitIn <= 1'b0;
		wait_rises(3);
		chk(lastTog, 2, "space full cycle");
		chk(rawData, 1'b0, "raw space");
		chk(retimedData, 1'b0, "retimed space");
		chk(lastRx, 1, "recovered clock per bit");
		chk(carrierDetect, 1'b1, "tone present");
		axi_rd(fmc_pkg::ADDR_STATUS);
		chk(rd[0], 1'b1, "status tone present");
		$display("test loopback done");
	endtask

	task automatic t_powersave;
		logic cdHeld, clkHeld;
		@(posedge clk);
		rxEnable <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(retimedData, 1'b0, "rx off retimed");
		cdHeld = carrierDetect;
		clkHeld = rxClock;
		wait_rises(1);
		chk(txToneOe, 1'b1, "tx runs with rx off");
		chk(carrierDetect, cdHeld, "rx off flag static");
		chk(rxClock, clkHeld, "rx off clock static");
		@(posedge clk);
		transmitOnLow <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(txSync, 1'b1, "tx off bit clock");
		chk(txToneOe, 1'b0, "tx off tone released");
		@(posedge clk);
		rxEnable <= 1'b1;
		repeat (300) @(posedge clk);
		@(negedge clk);
		chk(carrierDetect, 1'b0, "noise only");
		$display("test powersave done");
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset_regs();
		t_rate_table();
		t_tx_timing();
		t_loopback();
		t_powersave();
		report_and_stop();
	end

	// cuts a hang short after about 90000 cycles
	initial begin
		#3600000;
		errTotal++;
		$display("Error at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
